// *** core/til_target_latency.sv ***
`include "til_cfg.svh"
module til_target_latency #(
  parameter int INIT_CLOCKS = `TIL_INIT_CLOCKS,
  parameter int RUN_LIMIT = `TIL_RUN_LIMIT,
  parameter int HOST_LIMIT = `TIL_HOST_LIMIT,
  parameter int LAT_W = `TIL_LAT_WIDTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic FRAME_N,
  input wire logic IRDY_N,
  input wire logic HIT,
  input wire logic [1:0] ACC_CLASS,
  input wire logic IS_WRITE,
  input wire logic BUSY,
  input wire logic DATA_READY,
  input wire logic HOST_MOD_HIT,
  input wire logic POST_FULL,
  input wire logic BOOT_STRAP,
  output logic DEVSEL_N_O,
  output logic DEVSEL_OE,
  output logic TRDY_N_O,
  output logic TRDY_OE,
  output logic STOP_N_O,
  output logic STOP_OE,
  output logic DT_START,
  output logic POST_PUSH,
  output logic XFER_ACK,
  output logic INIT_TIME,
  output logic LAT_VALID,
  output logic [LAT_W-1:0] LAT_CYCLES
);
  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (RUN_LIMIT < 2 || HOST_LIMIT < RUN_LIMIT || HOST_LIMIT >= (2 ** LAT_W)) begin : g_bad
    $error("til_target_latency: latency limits do not fit the counter");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  til_pkg::til_req_type req;
  til_pkg::til_state_type state;
  til_pkg::til_pins_type pins;
  logic frame_q;
  logic boot;
  logic boot_taken;
  logic init_run;
  logic in_init;
  logic is_post;
  logic [LAT_W-1:0] lat_cnt;
  logic [LAT_W-1:0] limit;
  logic start;
  logic claim;
  logic imm_xfer;
  logic post_refuse;
  logic go_wait;
  logic expire;
  logic wait_end;
  logic first_end;

  // bus pins share this clock, so no synchroniser is placed on them
  assign req = '{
    cls: til_pkg::til_class_type'(ACC_CLASS),
    is_write: IS_WRITE,
    busy: BUSY,
    data_ready: DATA_READY,
    post_full: POST_FULL
  };

  // ****************************************************************
  // init-time tracking
  // ****************************************************************
  til_sat_counter #(
    .TERMINAL(INIT_CLOCKS)
  ) u_init (
    .clk(CLK),
    .rst(RST),
    .running(init_run)
  );

  // strap is caught on the first edge after release, never by the reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      boot <= 1'b0;
      boot_taken <= 1'b0;
    end else if (!boot_taken) begin
      boot <= BOOT_STRAP;
      boot_taken <= 1'b1;
    end
  end

  // previous frame level, for the address phase edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frame_q <= 1'b1;
    end else begin
      frame_q <= FRAME_N;
    end
  end

  // ****************************************************************
  // claim decision
  // ****************************************************************
  // address phase: frame newly asserted while idle and decoded as ours
  assign start = (state == til_pkg::TIL_IDLE) && frame_q && !FRAME_N && HIT;
  // a strap not yet taken counts as non-boot for that first clock
  assign claim = start && (!init_run || boot);
  // registers and posted writes answer at once, as does ready data
  assign imm_xfer = (req.cls == til_pkg::TIL_CLS_REG) ||
                    ((req.cls == til_pkg::TIL_CLS_POST) && req.is_write && !req.post_full) ||
                    req.data_ready;
  // full post buffer is a short conflict: plain retry, reissue likely succeeds
  assign post_refuse = (req.cls == til_pkg::TIL_CLS_POST) && req.is_write && req.post_full;
  assign go_wait = !req.busy && !imm_xfer && !post_refuse &&
                   ((req.cls == til_pkg::TIL_CLS_COUNT) || init_run);
  // run-time watchdog fires so stop is sampled on the limit clock
  assign expire = in_init ? !init_run : (lat_cnt == limit - 1'b1);
  assign wait_end = (state == til_pkg::TIL_WAIT) && (req.data_ready || expire);
  assign first_end = (claim && !go_wait) || wait_end;

  // ****************************************************************
  // target sequencer
  // ****************************************************************
  // drives devsel, trdy and stop; one clock high before release of the pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= til_pkg::TIL_IDLE;
      pins <= '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, oe: 1'b0};
      DT_START <= 1'b0;
      POST_PUSH <= 1'b0;
      XFER_ACK <= 1'b0;
      in_init <= 1'b0;
      is_post <= 1'b0;
    end else begin
      DT_START <= 1'b0;
      POST_PUSH <= 1'b0;
      XFER_ACK <= 1'b0;
      case (state)
        til_pkg::TIL_IDLE: begin
          if (claim) begin
            pins.oe <= 1'b1;
            pins.devsel_n <= 1'b0;
            in_init <= init_run;
            is_post <= (req.cls == til_pkg::TIL_CLS_POST) && req.is_write;
            if (req.busy) begin
              pins.stop_n <= 1'b0;
              state <= til_pkg::TIL_RETRY;
            end else if (imm_xfer) begin
              pins.trdy_n <= 1'b0;
              state <= til_pkg::TIL_XFER;
            end else if (post_refuse) begin
              pins.stop_n <= 1'b0;
              state <= til_pkg::TIL_RETRY;
            end else if (go_wait) begin
              state <= til_pkg::TIL_WAIT;
            end else begin
              // slow region: retry now instead of burning the limit
              pins.stop_n <= 1'b0;
              DT_START <= 1'b1;
              state <= til_pkg::TIL_RETRY;
            end
          end
        end
        til_pkg::TIL_WAIT: begin
          if (req.data_ready) begin
            pins.trdy_n <= 1'b0;
            state <= til_pkg::TIL_XFER;
          end else if (expire) begin
            pins.stop_n <= 1'b0;
            DT_START <= 1'b1;
            state <= til_pkg::TIL_RETRY;
          end
        end
        til_pkg::TIL_XFER: begin
          // trdy stays for later phases; their latency is handled elsewhere
          if (!IRDY_N) begin
            XFER_ACK <= 1'b1;
            POST_PUSH <= is_post;
            if (FRAME_N) begin
              pins.trdy_n <= 1'b1;
              pins.devsel_n <= 1'b1;
              state <= til_pkg::TIL_DONE;
            end
          end
        end
        til_pkg::TIL_RETRY: begin
          // stop held until the master drops frame; it reissues later
          if (FRAME_N) begin
            pins.stop_n <= 1'b1;
            pins.devsel_n <= 1'b1;
            state <= til_pkg::TIL_DONE;
          end
        end
        til_pkg::TIL_DONE: begin
          pins.oe <= 1'b0;
          state <= til_pkg::TIL_IDLE;
        end
        default: begin
          state <= til_pkg::TIL_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // initial latency counter
  // ****************************************************************
  // clock 1 is the address phase; saturates during long init-time waits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lat_cnt <= '0;
      limit <= LAT_W'(RUN_LIMIT);
    end else if (start) begin
      lat_cnt <= LAT_W'(1);
      limit <= HOST_MOD_HIT ? LAT_W'(HOST_LIMIT) : LAT_W'(RUN_LIMIT);
    end else if (state == til_pkg::TIL_WAIT && lat_cnt != '1) begin
      lat_cnt <= lat_cnt + 1'b1;
    end
  end

  // measured latency of each first phase, one pulse per claimed access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LAT_VALID <= 1'b0;
      LAT_CYCLES <= '0;
    end else begin
      LAT_VALID <= first_end;
      if (first_end) begin
        LAT_CYCLES <= wait_end ? LAT_W'(lat_cnt + 1'b1) : LAT_W'(1);
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign DEVSEL_N_O = pins.devsel_n;
  assign TRDY_N_O = pins.trdy_n;
  assign STOP_N_O = pins.stop_n;
  assign DEVSEL_OE = pins.oe;
  assign TRDY_OE = pins.oe;
  assign STOP_OE = pins.oe;
  assign INIT_TIME = init_run;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_claim_run;
    claim && !init_run && !req.busy;
  endsequence
  sequence s_phase_end;
    !pins.trdy_n || !pins.stop_n;
  endsequence

  a_init_ignore: assert property (
    start && init_run && !boot |=> !pins.oe && state == til_pkg::TIL_IDLE)
    else $error("non-boot target claimed during init-time");
  a_boot_claim: assert property (
    start && boot |=> !pins.devsel_n && pins.oe)
    else $error("boot target ignored an access");
  a_run_limit: assert property (
    claim && !init_run && !HOST_MOD_HIT |=> ##[0:15] s_phase_end)
    else $error("first phase exceeded the run-time limit");
  a_host_limit: assert property (
    claim && !init_run && HOST_MOD_HIT |=> ##[0:31] s_phase_end)
    else $error("first phase exceeded the host bridge limit");
  a_watchdog_stop: assert property (
    state == til_pkg::TIL_WAIT && !in_init && lat_cnt == limit - 1'b1 && !DATA_READY
    |=> !pins.stop_n && pins.trdy_n && DT_START)
    else $error("latency counter did not force retry on time");
  a_busy_retry: assert property (
    claim && BUSY |=> !pins.devsel_n && !pins.stop_n && pins.trdy_n)
    else $error("busy access not retried at once");
  a_delay_now: assert property (
    s_claim_run ##0 (req.cls == til_pkg::TIL_CLS_DELAY && !DATA_READY)
    |=> !pins.stop_n && DT_START)
    else $error("slow access not retried immediately as delayed");
  a_reg_immediate: assert property (
    s_claim_run ##0 (req.cls == til_pkg::TIL_CLS_REG) |=> !pins.trdy_n && LAT_VALID)
    else $error("register access not answered at once");
  a_post_commit: assert property (
    state == til_pkg::TIL_XFER && is_post && !IRDY_N |=> POST_PUSH && XFER_ACK)
    else $error("posted write not pushed to buffer");
  a_init_bound: assert property (
    state == til_pkg::TIL_WAIT && in_init && !init_run && !DATA_READY
    |=> !pins.stop_n && state == til_pkg::TIL_RETRY)
    else $error("init-time wait outlived init-time");
  a_lat_report: assert property (
    LAT_VALID && !in_init |-> LAT_CYCLES >= LAT_W'(1) && LAT_CYCLES <= limit)
    else $error("reported latency outside the limit");
  a_end_exclusive: assert property (
    pins.oe |-> pins.trdy_n || pins.stop_n)
    else $error("trdy and stop asserted together");
  a_done_release: assert property (
    state == til_pkg::TIL_DONE |->
    (pins.devsel_n && pins.trdy_n && pins.stop_n) ##1 !pins.oe)
    else $error("control pins not released after the access");
  a_xfer_ack: assert property (
    state == til_pkg::TIL_XFER && !IRDY_N |=> XFER_ACK)
    else $error("completed data phase not acknowledged");
  a_dt_pulse: assert property (
    DT_START |=> !DT_START)
    else $error("delayed start held longer than one clock");
endmodule : til_target_latency

// *** pkg/til_cfg.svh ***
`ifndef TIL_CFG_SVH
`define TIL_CFG_SVH
// Summary of operation
// - latency is clocks from frame start until trdy or stop ends first phase
// - first two to the 25th clocks after reset release are init-time, then run-time
// - non-boot target ignores accesses during init-time; boot device always claims (here not on the first clock after reset release, before the strap is taken)
// - during init-time claim and wait until done before init-time ends, or retry
// - in run-time the first data phase ends within 16 clocks of frame start
// - first phase ends by trdy for data or stop for termination, inside limit
// - host bridge hitting a modified line gets 32 clocks, never more
// - access known to be slow is retried at once and run as delayed transaction
// - unknown latency uses a counter forcing stop and delayed start by clock 16
// - do not idle until the counter expires before starting a delayed transaction
// - occasional overrun may retry within 16 clocks only if reissue likely completes
// - targets unable to meet the limit otherwise use delayed transactions
// - internal busy claims with devsel and retries at once, not at the limit
// - memory writes are posted into a buffer so write latency stays short
// - latency strategy may differ per access class, registers answer at once

// ****************************************************************
// latency limits and counts, in bus clocks
// ****************************************************************
`define TIL_RUN_LIMIT 16
`define TIL_HOST_LIMIT 32
`define TIL_INIT_CLOCKS 33554432
`define TIL_LAT_WIDTH 6

// ****************************************************************
// encodings
// ****************************************************************
`define TIL_ST_IDLE 3'h0
`define TIL_ST_WAIT 3'h1
`define TIL_ST_XFER 3'h3
`define TIL_ST_DONE 3'h2
`define TIL_ST_RETRY 3'h6
`define TIL_CLS_REG 2'h0
`define TIL_CLS_POST 2'h1
`define TIL_CLS_DELAY 2'h2
`define TIL_CLS_COUNT 2'h3
`endif

// *** pkg/til_pkg.sv ***
`include "til_cfg.svh"
package til_pkg;
  // sequencer states, gray along idle-wait-xfer-done
  typedef enum logic [2:0] {
    TIL_IDLE = `TIL_ST_IDLE,
    TIL_WAIT = `TIL_ST_WAIT,
    TIL_XFER = `TIL_ST_XFER,
    TIL_DONE = `TIL_ST_DONE,
    TIL_RETRY = `TIL_ST_RETRY
  } til_state_type;

  // latency strategy of the decoded region
  typedef enum logic [1:0] {
    TIL_CLS_REG = `TIL_CLS_REG,
    TIL_CLS_POST = `TIL_CLS_POST,
    TIL_CLS_DELAY = `TIL_CLS_DELAY,
    TIL_CLS_COUNT = `TIL_CLS_COUNT
  } til_class_type;

  // request side as seen at the address phase
  typedef struct packed {
    til_class_type cls;
    logic is_write;
    logic busy;
    logic data_ready;
    logic post_full;
  } til_req_type;

  // target control pins, all sharing one enable
  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic oe;
  } til_pins_type;
endpackage : til_pkg

// *** core/til_sat_counter.sv ***
`include "til_cfg.svh"
module til_sat_counter #(
  parameter int TERMINAL = `TIL_INIT_CLOCKS,
  parameter int WIDTH = $clog2(TERMINAL + 1)
) (
  input wire logic clk,
  input wire logic rst,
  output logic running
);
  logic [WIDTH-1:0] count;

  if (TERMINAL < 2 || WIDTH < $clog2(TERMINAL + 1)) begin : g_bad
    $error("til_sat_counter: terminal count unusable");
  end

  // ****************************************************************
  // init-time counter
  // ****************************************************************
  // held clear in reset, stops at terminal so run-time never ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b1;
    end else if (running) begin
      count <= count + 1'b1;
      if (count == WIDTH'(TERMINAL - 1)) begin
        running <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_init_end_edge: assert property (
    running && count == WIDTH'(TERMINAL - 1) |=> !running && count == WIDTH'(TERMINAL))
    else $error("init-time did not end at terminal count");
  a_init_saturate: assert property (
    !running |=> !running && $stable(count))
    else $error("init counter left saturation");
  a_init_counting: assert property (
    running && !rst |=> count == $past(count) + 1'b1) // release edge still in reset
    else $error("init counter stalled during init-time");
endmodule : til_sat_counter

// *** bench/til_bus_master.sv ***
// ****************************************************************
// initiator model: single-phase transfers, pull-ups when idle
// ****************************************************************
module til_bus_master (
  input wire logic CLK,
  input wire logic TRDY_N,
  input wire logic STOP_N,
  output logic FRAME_N,
  output logic IRDY_N
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus, lines held by pull-ups
  initial begin
    FRAME_N = 1'b1;
    IRDY_N = 1'b1;
  end

  // one access; lat counts edges from the claim edge, 0 when nobody answers
  task automatic access(output int lat);
    int n;
    @(posedge CLK);
    FRAME_N <= 1'b0;
    @(posedge CLK);
    FRAME_N <= 1'b1; // last phase is the first
    IRDY_N <= 1'b0;
    lat = 0;
    // slow targets are waited for well past the limit before aborting
    for (n = 1; n <= 40 && lat == 0; n++) begin
      @(posedge CLK);
      if (TRDY_N === 1'b0 || STOP_N === 1'b0) lat = n;
    end
    IRDY_N <= 1'b1;
    repeat (2) @(posedge CLK);
  endtask : access
endmodule : til_bus_master

// *** bench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT = 64;
  typedef struct packed {logic any; logic [5:0] lat; logic stop; logic dt;} til_exp_type;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk;
  logic rst = 1'b1;
  logic hit = 1'b0;
  logic [1:0] acc_class = 2'h0;
  logic is_write = 1'b0;
  logic busy = 1'b0;
  logic data_ready = 1'b0;
  logic host_mod_hit = 1'b0;
  logic post_full = 1'b0;
  logic boot_strap = 1'b1;
  logic frame_n, irdy_n, devsel_n, devsel_oe, trdy_n, trdy_oe, stop_n, stop_oe;
  logic dt_start, post_push, init_time, lat_valid, xfer_ack;
  logic [5:0] lat_cycles;
  logic [31:0] seed = 32'h0b937b04;
  int err_total = 0;
  int comparisons = 0;
  int pushes = 0;
  int acks = 0;
  int cyc = 0;
  int rel = 0;
  til_exp_type exp_q[$];
  til_exp_type got;
  wire trdy_bus = trdy_oe ? trdy_n : 1'b1; // pulled up when released
  wire stop_bus = stop_oe ? stop_n : 1'b1;

  til_target_latency #(.INIT_CLOCKS(INIT)) dut_u (.CLK(clk), .RST(rst), .FRAME_N(frame_n),
    .IRDY_N(irdy_n), .HIT(hit), .ACC_CLASS(acc_class), .IS_WRITE(is_write), .BUSY(busy),
    .DATA_READY(data_ready), .HOST_MOD_HIT(host_mod_hit), .POST_FULL(post_full),
    .BOOT_STRAP(boot_strap), .DEVSEL_N_O(devsel_n), .DEVSEL_OE(devsel_oe),
    .TRDY_N_O(trdy_n), .TRDY_OE(trdy_oe), .STOP_N_O(stop_n), .STOP_OE(stop_oe),
    .DT_START(dt_start), .POST_PUSH(post_push), .XFER_ACK(xfer_ack), .INIT_TIME(init_time),
    .LAT_VALID(lat_valid), .LAT_CYCLES(lat_cycles));
  til_bus_master m_u (.CLK(clk), .TRDY_N(trdy_bus), .STOP_N(stop_bus), .FRAME_N(frame_n),
    .IRDY_N(irdy_n));

  // 100 ns bus clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic results;
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic do_reset(input logic boot);
    rst <= 1'b1;
    boot_strap <= boot;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rel = cyc;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // decode inputs held from before the claim edge until the access ends
  task automatic op(input logic [1:0] cls, input logic wr, input logic bsy, input logic full,
      input logic host, input til_exp_type e, input int lim);
    int lat;
    @(posedge clk);
    hit <= 1'b1;
    acc_class <= cls;
    is_write <= wr;
    busy <= bsy;
    post_full <= full;
    host_mod_hit <= host;
    exp_q.push_back(e);
    m_u.access(lat);
    check(32'(lat >= 1 && lat <= lim), 32'h1);
    hit <= 1'b0;
  endtask : op

  // ****************************************************************
  // watchers: edge count, posted pushes, latency scoreboard
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (post_push === 1'b1) pushes <= pushes + 1;
    if (xfer_ack === 1'b1) acks <= acks + 1;
  end

  // oldest note is matched against each reported first phase
  always @(posedge clk) begin
    if (lat_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        got = exp_q.pop_front();
        if (!got.any) check(32'(lat_cycles), 32'(got.lat));
        check({stop_n, dt_start}, {~got.stop, got.dt});
        check({devsel_n, devsel_oe, trdy_oe, stop_oe}, 4'h7);
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n;
    int lat;
    do_reset(1'b1);
    op(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b0, 1'b0}, 16);
    for (n = 0; n < INIT && cyc - rel < INIT - 1; n++) @(posedge clk);
    check(32'(n < INIT), 32'h1);
    @(negedge clk);
    check(init_time, 1'b1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(init_time, 1'b0);
    // registers answer at once whatever the direction
    for (n = 0; n < 3; n++) begin
      seed = lfsr(seed);
      op(2'h0, seed[0], 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b0, 1'b0}, 16);
    end
    op(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b0, 1'b0}, 16);
    op(2'h1, 1'b1, 1'b0, 1'b1, 1'b0, '{1'b0, 6'h1, 1'b1, 1'b0}, 16);
    op(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b1, 1'b1}, 16);
    op(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b1, 1'b1}, 16);
    op(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b1, 1'b0}, 16);
    op(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h1, 1'b0, 1'b0}, 16);
    op(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b0, 6'h10, 1'b1, 1'b1}, 16);
    op(2'h3, 1'b0, 1'b0, 1'b0, 1'b1, '{1'b0, 6'h20, 1'b1, 1'b1}, 32);
    // counted access whose data shows up at a random point inside the limit
    seed = lfsr(seed);
    fork
      op(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b1, 6'h0, 1'b0, 1'b0}, 16);
      begin
        repeat (3 + seed[2:0]) @(posedge clk);
        data_ready <= 1'b1;
      end
    join
    data_ready <= 1'b0;
    check(init_time, 1'b0);
    check(pushes, 32'h1);
    check(acks, 32'h7);
    // second reset, non-boot strap: decoded accesses still go unclaimed
    do_reset(1'b0);
    check(init_time, 1'b1);
    hit <= 1'b1;
    m_u.access(lat);
    hit <= 1'b0;
    check(lat, 32'h0);
    // boot strap again: slow access waits out init-time, then retries
    do_reset(1'b1);
    for (n = 0; n < INIT && cyc - rel < INIT - 24; n++) @(posedge clk);
    check(32'(n < INIT), 32'h1);
    op(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, '{1'b1, 6'h0, 1'b1, 1'b1}, 40);
    check(exp_q.size(), 32'h0);
    results();
  end
endmodule : testbench
